// ==== rtl/scp_defs.svh ====
// Purpose: constants for the control serial port
// Assumes: 100 MHz system clock
// Notes: timing counts derived from the clock period
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SERIAL_SHIFT_CLOCK_PERIOD_NS 10
`define SCP_BITS 8
`define SCP_BIT_CNT_W 4
`define SCP_BAUD_W 2
`define SCP_DIV_W 4
`define SCP_FIFO_DEPTH 16
`define SCP_CMD_W 8
`define SCP_READ_ZERO 8'h00
`define SCP_RESET_SHIFT 8'h00
`endif

// ==== rtl/scp_pkg.sv ====
// Purpose: types for the control serial port
// Assumes: used with scp_defs.svh
// Notes: types only
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_IDLE,
        SCP_SETUP,
        SCP_SHIFT
    } scp_state_t;

    typedef struct packed {
        logic master;
        logic clock_invert_bit;
        logic [1:0] baud;
        logic port_enable_bit_0;
        logic port_enable_bit_1;
        logic sel_en_0;
        logic sel_en_1;
    } scp_ctrl_t;

    typedef struct packed {
        logic busy;
        logic complete;
        logic [7:0] data;
    } scp_stat_t;
endpackage

// ==== rtl/scp_fifo.sv ====
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes: full and empty derived from a count
`timescale 1ns/10ps
module scp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop)
            begin
                rd_r <= rd_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ==== rtl/scp_port.sv ====
// Purpose: byte-exchange serial control port, master or slave
// Assumes: all inputs synchronous to clk; slave clock at most clk/2
// Notes: host writes queue through a FIFO; shift register host access
//
// Notes on behaviour
// - full duplex eight-bit exchange bursts
// - master drives clock, slave accepts it
// - busy: writes wait in queue, reads zero
// - control and status always accessible
// - baud bits pick divider tap
// - channel 0 enable takes pins
// - channel 1 enable gives select 1
// - select falls only with idle clock; not enforced here, selects follow the bits at once
// - master selects follow enable bits
// - master clock idles, eight pulses
// - normal: msb first, out rise
// - invert swaps the edges
// - sampled bits replace sent bits
// - eighth shift clears transmit, sets complete
// - shifting starts within 1.5 periods
// - slave: select 0, clock become inputs
// - slave completion on select rise
// - slave clock up to half clk
// - slave first bit on first edge
// - short burst shifts partially
// - long burst keeps shifting
`timescale 1ns/10ps
`include "scp_defs.svh"
module scp_port
    import scp_pkg::*;
#(
    parameter int FIFO_DEPTH = `SCP_FIFO_DEPTH
)
(
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // configuration and control
    input wire scp_ctrl_t ctrl,
    input wire logic status_clear,
    // host shift-register access
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    input wire logic start,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    output scp_stat_t status,
    // serial pins
    output logic serial_shift_clock,
    output logic serial_shift_clock_oe,
    input wire logic serial_shift_clock_in,
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    output logic select_out_0,
    output logic select_out_0_oe,
    input wire logic select_in_0,
    output logic select_out_1,
    output logic select_out_1_oe
);
    // -----------------------------------------
    // declarations
    // -----------------------------------------
    scp_state_t state_r;
    logic [7:0] shreg_r;
    logic [`SCP_BIT_CNT_W-1:0] bits_r;
    logic [`SCP_DIV_W-1:0] div_r;
    logic [`SCP_DIV_W-1:0] div_nxt;
    logic sck_r;
    logic sck_nxt;
    logic last_fall;
    logic pend_r;
    logic complete_r;
    logic sck_in_d_r;
    logic sel_in_d_r;
    logic tick;
    logic busy;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic lead_edge;
    logic trail_edge;
    logic slave_act;

    // wait count half: tap is 2^(baud+1), half period 2^baud
    function automatic logic [`SCP_DIV_W-1:0] half_period(input logic [1:0] b);
        half_period = `SCP_DIV_W'(1 << b) - 1'b1;
    endfunction

    // count of completed trailing edges says this was the last one
    function automatic logic is_last(input logic [`SCP_BIT_CNT_W-1:0] n);
        is_last = (n == `SCP_BIT_CNT_W'(`SCP_BITS - 1));
    endfunction

    // -----------------------------------------
    // host write queue
    // -----------------------------------------
    scp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign slave_act = !ctrl.master && !sel_in_d_r;
    assign busy = (state_r != SCP_IDLE) || slave_act || pend_r;
    // write held while busy: queue drains only when idle; stalled
    // entries wait rather than drop, so back-pressure reaches the host
    assign f_ready = !busy;

    // -----------------------------------------
    // baud divider
    // -----------------------------------------
    // tap chosen by baud bits
    always_comb
    begin
        div_nxt = div_r - 1'b1;
        tick = (div_r == '0);
        if (tick)
        begin
            div_nxt = half_period(ctrl.baud);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_r <= '0;
        end
        else if (ce)
        begin
            div_r <= div_nxt;
        end
    end

    // -----------------------------------------
    // slave input history
    // -----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sck_in_d_r <= 1'b0;
            sel_in_d_r <= 1'b1;
        end
        else if (ce)
        begin
            sck_in_d_r <= serial_shift_clock_in;
            sel_in_d_r <= select_in_0;
        end
    end

    // one register stage: edges seen up to half clk
    assign lead_edge = ctrl.clock_invert_bit ? (sck_in_d_r && !serial_shift_clock_in)
                                             : (!sck_in_d_r && serial_shift_clock_in);
    assign trail_edge = ctrl.clock_invert_bit ? (!sck_in_d_r && serial_shift_clock_in)
                                              : (sck_in_d_r && !serial_shift_clock_in);

    // -----------------------------------------
    // master sequencer and shift register
    // -----------------------------------------
    // clock level a step ahead: pin, data and sampling share one edge
    // so a slave answering on the leading edge is never sampled too early
    always_comb
    begin
        sck_nxt = sck_r;
        if (state_r == SCP_IDLE)
        begin
            sck_nxt = pend_r && tick;
        end
        else if (state_r == SCP_SHIFT && tick)
        begin
            sck_nxt = !sck_r;
        end
    end

    // trailing edge of the eighth pulse
    assign last_fall = (state_r == SCP_SHIFT) && tick && sck_r && is_last(bits_r);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= SCP_IDLE;
            shreg_r <= `SCP_RESET_SHIFT;
            bits_r <= '0;
            sck_r <= 1'b0;
            pend_r <= 1'b0;
            serial_out_pin <= 1'b1;
        end
        else if (ce)
        begin
            if (f_valid && f_ready)
            begin
                shreg_r <= f_data;
                serial_out_pin <= f_data[7];
            end
            if (start && ctrl.master && state_r == SCP_IDLE)
            begin
                pend_r <= 1'b1;
            end
            sck_r <= sck_nxt;
            case (state_r)
                SCP_IDLE:
                begin
                    if (pend_r && tick)
                    begin
                        pend_r <= 1'b0;
                        bits_r <= '0;
                        state_r <= SCP_SHIFT;
                        serial_out_pin <= shreg_r[7];
                    end
                    // slave drives msb on each leading edge
                    else if (slave_act && lead_edge)
                    begin
                        serial_out_pin <= shreg_r[7];
                    end
                    else if (slave_act && trail_edge)
                    begin
                        // partial shift; continues past eight
                        // output waits for the next leading edge
                        shreg_r <= {shreg_r[6:0], serial_in_pin};
                    end
                end
                SCP_SHIFT:
                begin
                    if (tick && sck_r)
                    begin
                        shreg_r <= {shreg_r[6:0], serial_in_pin};
                        bits_r <= bits_r + 1'b1;
                        if (is_last(bits_r))
                        begin
                            state_r <= SCP_IDLE;
                        end
                    end
                    else if (tick)
                    begin
                        // next bit with the leading edge
                        serial_out_pin <= shreg_r[7];
                    end
                end
                default:
                begin
                    state_r <= SCP_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------
    // completion flag
    // -----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            complete_r <= 1'b0;
        end
        else if (ce)
        begin
            // set after eighth shift; on select rise; set wins
            if (last_fall || (!ctrl.master && !sel_in_d_r && select_in_0))
            begin
                complete_r <= 1'b1;
            end
            else if (status_clear)
            begin
                complete_r <= 1'b0;
            end
        end
    end

    // -----------------------------------------
    // host read and status
    // -----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_data <= `SCP_READ_ZERO;
            status <= '0;
        end
        else if (ce)
        begin
            if (rd_strobe)
            begin
                rd_data <= busy ? `SCP_READ_ZERO : shreg_r;
            end
            // status always visible; busy doubles as transmit bit
            status <= '{busy: busy, complete: complete_r, data: shreg_r};
        end
    end

    // -----------------------------------------
    // pin muxing
    // -----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            serial_shift_clock <= 1'b0;
            serial_shift_clock_oe <= 1'b0;
            select_out_0 <= 1'b1;
            select_out_0_oe <= 1'b0;
            select_out_1 <= 1'b1;
            select_out_1_oe <= 1'b0;
        end
        else if (ce)
        begin
            serial_shift_clock <= sck_nxt ^ ctrl.clock_invert_bit;
            serial_shift_clock_oe <= ctrl.port_enable_bit_0 && ctrl.master;
            // selects follow bits; host sets them with clock idle
            select_out_0 <= !ctrl.sel_en_0;
            select_out_0_oe <= ctrl.port_enable_bit_0 && ctrl.master;
            // carrier detect pin as select 1
            select_out_1 <= !ctrl.sel_en_1;
            select_out_1_oe <= ctrl.port_enable_bit_1;
        end
    end
endmodule

// ==== test/scp_port_assertions.sv ====
// Purpose: pin relations of the control serial port
// Assumes: sees scp_port ports only
// Notes: clock edges counted from each start
`timescale 1ns/10ps
module scp_port_assertions
    import scp_pkg::*;
(
    // clocking and control
    input wire logic clk,
    input wire logic rst,
    input wire scp_ctrl_t ctrl,
    input wire logic start,
    input wire logic rd_strobe,
    // observed
    input wire logic [7:0] rd_data,
    input wire scp_stat_t status,
    input wire logic serial_shift_clock,
    input wire logic serial_shift_clock_oe,
    input wire logic serial_out_pin,
    input wire logic select_out_0,
    input wire logic select_out_1
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----
    // edge count
    // ----
    logic [4:0] edges_r;
    always_ff @(posedge clk)
    begin
        if (rst || start)
            edges_r <= 5'h00;
        else if ($changed(serial_shift_clock))
            edges_r <= edges_r + 5'h01;
    end
    AST_EIGHT: assert property ($fell(status.busy) && ctrl.master |=> edges_r == 5'h10)
        else $error("pulse count wrong");
    AST_IDLE: assert property (ctrl.master && !status.busy && $stable(ctrl) && !$past(rst)
        |-> serial_shift_clock == ctrl.clock_invert_bit)
        else $error("clock not idle");
    AST_START: assert property (start && ctrl.master && !status.busy
        |-> ##[1:40] $changed(serial_shift_clock))
        else $error("shift start late");
    AST_DONE: assert property ($fell(status.busy) && ctrl.master |-> status.complete)
        else $error("complete missing");
    AST_ZERO: assert property (rd_strobe ##1 status.busy |-> rd_data == 8'h00)
        else $error("busy read not zero");
    AST_SEL0: assert property ($changed(ctrl.sel_en_0) && ctrl.master && ctrl.port_enable_bit_0
        |=> select_out_0 == !$past(ctrl.sel_en_0))
        else $error("select 0 late");
    AST_SEL1: assert property ($changed(ctrl.sel_en_1) && ctrl.port_enable_bit_1
        |=> select_out_1 == !$past(ctrl.sel_en_1))
        else $error("select 1 late");
    AST_OE: assert property (!$past(rst) && $stable(ctrl)
        |-> serial_shift_clock_oe == (ctrl.master && ctrl.port_enable_bit_0))
        else $error("clock enable wrong");
    AST_MSB: assert property (ctrl.master && !ctrl.clock_invert_bit && status.busy
        && $past(status.busy) && $changed(serial_out_pin) |-> $rose(serial_shift_clock))
        else $error("data moved off rising edge");
endmodule
bind scp_port scp_port_assertions u_chk (.clk, .rst, .ctrl, .start, .rd_strobe, .rd_data,
    .status, .serial_shift_clock, .serial_shift_clock_oe, .serial_out_pin, .select_out_0,
    .select_out_1);

// ==== test/scp_slave_model.sv ====
// Purpose: serial peripheral answering the master port
// Assumes: select active low
// Notes: a released data line shows the inverse bit
`timescale 1ns/10ps
module scp_slave_model
(
    // pins
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic cinv,
    output logic miso,
    // bench side
    input wire logic [7:0] reply,
    output logic [7:0] got
);
    logic [7:0] sh;
    wire logic lead = sck ^ cinv;
    initial miso = 1'b0;
    always @(negedge sel_n)
        sh = reply;
    always @(posedge lead)
    begin
        if (!sel_n)
        begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end
    end
    always @(negedge lead)
        if (!sel_n)
            got = {got[6:0], mosi};
    // no stale bit held
    always @(posedge sel_n)
        miso = ~miso;
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the control serial port
// Assumes: 100 MHz clock, reset held 12 cycles
// Notes: slave mode pins driven here; slave clock at clk/8
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module tb
    import scp_pkg::*;
;
    logic clk, rst, ce, sclr, wv, start, rds, sck_i, sel_i, si_tb;
    logic [7:0] wd, rdd, reply, got, sr;
    logic wrdy, sck, sck_oe, so, so0, so0_oe, so1, miso;
    scp_ctrl_t c;
    scp_stat_t st;
    int errors, checks;
    wire logic sck_w = sck_oe ? sck : sck_i;
    wire logic sel_w = so0_oe ? so0 : sel_i;
    wire logic sin = c.master ? miso : si_tb;
    scp_port u_dut (.clk(clk), .rst(rst), .ce(ce), .ctrl(c), .status_clear(sclr),
        .wr_valid(wv), .wr_ready(wrdy), .wr_data(wd), .start(start), .rd_strobe(rds),
        .rd_data(rdd), .status(st), .serial_shift_clock(sck), .serial_shift_clock_oe(sck_oe),
        .serial_shift_clock_in(sck_w), .serial_out_pin(so), .serial_in_pin(sin),
        .select_out_0(so0), .select_out_0_oe(so0_oe), .select_in_0(sel_w),
        .select_out_1(so1), .select_out_1_oe());
    scp_slave_model u_slv (.sck(sck_w), .sel_n(sel_w), .mosi(so), .cinv(c.clock_invert_bit),
        .miso(miso), .reply(reply), .got(got));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle;
        int i;
        for (i = 0; i < 900 && st.busy !== 1'b0; i++)
            tick(1);
        if (i == 900)
        begin
            errors++;
            give_verdict;
        end
    endtask
    task automatic pulse(input logic rd);
        rds <= rd;
        sclr <= !rd;
        tick(1);
        {rds, sclr} <= 2'h0;
        tick(2);
    endtask
    task automatic put(input logic [7:0] d);
        int i;
        wv <= 1'b1;
        wd <= d;
        tick(1);
        for (i = 0; i < 50 && wrdy !== 1'b1; i++)
            tick(1);
        wv <= 1'b0;
        if (i == 50)
        begin
            errors++;
            give_verdict;
        end
    endtask
    task automatic go;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(1);
    endtask
    task automatic t_rst;
        `CHK("status", 10'h000, st)
        `CHK("select 1", 1'b1, so1)
        `CHK("clock", 1'b0, sck)
        $display("reset test done");
    endtask
    task automatic xfer(input logic [7:0] d, r, input logic inv, input logic [1:0] b);
        c.clock_invert_bit <= inv;
        c.baud <= b;
        reply = r;
        put(d);
        tick(3);
        c.sel_en_0 <= 1'b1;
        tick(2);
        `CHK("select 0", 1'b0, so0)
        go;
        pulse(1'b1);
        `CHK("busy read", 8'h00, rdd)
        idle;
        `CHK("rx byte", r, st.data)
        `CHK("tx byte", d, got)
        `CHK("complete", 1'b1, st.complete)
        c.sel_en_0 <= 1'b0;
        tick(25);
        pulse(1'b1);
        `CHK("idle read", r, rdd)
        pulse(1'b0);
        `CHK("cleared", 1'b0, st.complete)
        $display("exchange %h done", d);
    endtask
    task automatic t_fifo;
        int n;
        n = 0;
        put(8'h11);
        tick(3);
        go;
        c.sel_en_1 <= 1'b1;
        tick(2);
        `CHK("select 1 busy", 1'b0, so1)
        wv <= 1'b1;
        wd <= 8'h40;
        repeat (40)
        begin
            tick(1);
            if (wrdy === 1'b1)
            begin
                n++;
                wd <= 8'h40 + 8'(n);
            end
        end
        wv <= 1'b0;
        `CHK("fifo count", 16, n)
        idle;
        tick(30);
        `CHK("last word", 8'h4F, st.data)
        c.sel_en_1 <= 1'b0;
        $display("fifo test done");
    endtask
    task automatic slv(input int n, input logic inv, input logic [15:0] pat);
        int k;
        c.master <= 1'b0;
        c.clock_invert_bit <= inv;
        sck_i <= inv;
        pulse(1'b0);
        `CHK("slave clear", 1'b0, st.complete)
        put(8'hA5);
        tick(3);
        sr = 8'hA5;
        sel_i <= 1'b0;
        tick(4);
        for (k = 0; k < n; k++)
        begin
            sck_i <= !inv;
            si_tb <= pat[k];
            tick(4);
            `CHK("slave out", sr[7], so)
            sck_i <= inv;
            tick(4);
            sr = {sr[6:0], pat[k]};
        end
        sel_i <= 1'b1;
        tick(4);
        `CHK("slave byte", sr, st.data)
        `CHK("slave done", 1'b1, st.complete)
        $display("slave burst %0d done", n);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        {sclr, wv, start, rds, sck_i, si_tb} = 6'h00;
        sel_i = 1'b1;
        wd = 8'h00;
        reply = 8'h00;
        c = 8'h8C;
        errors = 0;
        checks = 0;
        tick(12);
        rst <= 1'b0;
        tick(2);
        t_rst;
        xfer(8'hA5, 8'h3C, 1'b0, 2'h0);
        xfer(8'h96, 8'hC3, 1'b1, 2'h1);
        xfer(8'h01, 8'h80, 1'b0, 2'h2);
        xfer(8'hFE, 8'h7F, 1'b1, 2'h3);
        t_fifo;
        slv(8, 1'b0, 16'h00B4);
        slv(3, 1'b1, 16'h0005);
        slv(10, 1'b0, 16'h02C9);
        give_verdict;
    end
endmodule
